// ===== stop_recovery_select.sv
// Stop mode recovery source selection with an AXI4-Lite register slave.
// Overview of operation
// - Codes 000 POR, 001/010 port 2 NAND.
// - Codes 011/100 NOR/NAND of port 3 bits 1-3.
// - Codes 101/110 add port 0 bits 0, 7.
// - Level bit picks active low or high.
// - Reset gives POR only and low level.
// - Either primary or secondary event wakes core.
// - Pins set as outputs leave the equation.
// - Write-only register, source 4:2, level 6.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module stop_recovery_select
  import stop_recovery_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // AXI4-Lite write channels.
  input wire logic [31:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels.
  input wire logic [31:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Port pins and their directions, asynchronous.
  input wire pin_group_t pins_in,
  input wire pin_group_t pin_is_out_in,
  // Core power state and the primary recovery event.
  input wire logic stopped_in,
  input wire logic primary_wake_in,
  // Wake request to the core.
  output logic wake_out
);

  recovery_cfg_t cfg_r;
  logic res_err_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  pin_group_t pin_s1_r;
  pin_group_t pin_s2_r;
  pin_group_t dir_s1_r;
  pin_group_t dir_s2_r;
  logic term;
  logic wake_r;
  logic wake_nxt;
  logic do_write;

  function automatic logic [1:0] decode_resp(input logic [31:0] addr);
    if (addr == SEL2_ADDR || addr == STATUS_ADDR || addr == CTRL_ADDR) begin
      decode_resp = RESP_OKAY;
    end else begin
      decode_resp = RESP_DECERR;
    end
  endfunction

  assign s_axi_awready_out = !aw_hold_r && !bvalid_r;
  assign s_axi_wready_out = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      w_hold_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_hold_r <= 1'b1;
      w_data_r <= s_axi_wdata_in;
      w_strb_r <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= decode_resp(aw_addr_r);
    end else if (s_axi_bready_in) begin
      bvalid_r <= 1'b0;
    end
  end

  // Register write; reset gives POR only, level low.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cfg_r.source <= SRC_RESET;
      cfg_r.level <= LEVEL_RESET;
      res_err_r <= 1'b0;
    end else if (do_write && aw_addr_r == SEL2_ADDR && w_strb_r[0]) begin
      cfg_r.source <= w_data_r[SRC_LSB +: SRC_W];
      cfg_r.level <= w_data_r[LEVEL_BIT];
      if ((w_data_r[7:0] & RESERVED_MASK) != 8'h00) begin
        res_err_r <= 1'b1;
      end
    end else if (do_write && aw_addr_r == CTRL_ADDR && w_strb_r[0] &&
                 w_data_r[ST_RESERR_BIT]) begin
      res_err_r <= 1'b0;
    end
  end

  // The select register reads as zero; status shows block state.
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_r <= 1'b1;
      rresp_r <= decode_resp(s_axi_araddr_in);
      rdata_r <= '0;
      if (s_axi_araddr_in == STATUS_ADDR) begin
        rdata_r[ST_STOPPED_BIT] <= stopped_in;
        rdata_r[ST_WAKE_BIT] <= wake_r;
        rdata_r[ST_TERM_BIT] <= term;
        rdata_r[ST_RESERR_BIT] <= res_err_r;
      end
    end else if (s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      dir_s1_r <= '0;
      dir_s2_r <= '0;
    end else begin
      pin_s1_r <= pins_in;
      pin_s2_r <= pin_s1_r;
      dir_s1_r <= pin_is_out_in;
      dir_s2_r <= dir_s1_r;
    end
  end

  recovery_gate u_gate (
    .cfg_in(cfg_r),
    .pins_in(pin_s2_r),
    .is_out_in(dir_s2_r),
    .term_out(term)
  );

  assign wake_nxt = stopped_in && (term || primary_wake_in);

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  assign wake_out = wake_r;

  wake_follow_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    stopped_in && term |=> wake_out)
    else $error("Secondary term did not wake.");
  primary_wake_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    stopped_in && primary_wake_in |=> wake_out)
    else $error("Primary event did not wake.");
  no_run_wake_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    !stopped_in |=> !wake_out)
    else $error("Wake raised while running.");
  por_only_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    cfg_r.source == SRC_POR_ONLY |-> !term)
    else $error("POR only code gave a term.");
  reset_cfg_a: assert property (
    @(posedge clk_sys_in)
    !rstn_in |=> cfg_r.source == SRC_RESET && !cfg_r.level)
    else $error("Reset defaults wrong.");
  nand_p3_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    cfg_r.source == SRC_NAND_P3 && cfg_r.level && dir_s2_r.port3 == 4'h0
    |-> term == !(&pin_s2_r.port3[3:1]))
    else $error("Port 3 NAND wrong.");
  nor_p3p0_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    cfg_r.source == SRC_NOR_P3_P0 && cfg_r.level && dir_s2_r == '0
    |-> term == !(|{pin_s2_r.port3[3:1], pin_s2_r.port0[7],
                    pin_s2_r.port0[0]}))
    else $error("Port 3 and 0 NOR wrong.");
  out_ignored_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    cfg_r.source == SRC_NAND_P2_ALL && dir_s2_r.port2 == 8'hff |-> !term)
    else $error("Output pins not ignored.");
  level_low_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    cfg_r.source == SRC_NAND_P2_LO && !cfg_r.level && dir_s2_r.port2 == 8'h00
    |-> term == (&pin_s2_r.port2[3:0]))
    else $error("Low level select wrong.");
  read_zero_a: assert property (
    @(posedge clk_sys_in) disable iff (!rstn_in)
    s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == SEL2_ADDR
    |=> rvalid_r && rdata_r == 32'h0000_0000)
    else $error("Select register not write-only.");

endmodule

// ===== stop_recovery_pkg.sv
// Package with register map, field layout and carrier types of the recovery select block.
package stop_recovery_pkg;

  localparam logic [31:0] SEL2_OFFSET = 32'h0000_000d;
  localparam logic [31:0] SEL2_ADDR = SEL2_OFFSET << 2;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0040;
  localparam logic [31:0] CTRL_ADDR = 32'h0000_0044;
  localparam int SRC_LSB = 2;
  localparam int SRC_W = 3;
  localparam int LEVEL_BIT = 6;
  localparam logic [7:0] RESERVED_MASK = 8'ha3;
  localparam logic [2:0] SRC_RESET = 3'h0;
  localparam logic LEVEL_RESET = 1'b0;
  localparam logic [2:0] SRC_POR_ONLY = 3'h0;
  localparam logic [2:0] SRC_NAND_P2_LO = 3'h1;
  localparam logic [2:0] SRC_NAND_P2_ALL = 3'h2;
  localparam logic [2:0] SRC_NOR_P3 = 3'h3;
  localparam logic [2:0] SRC_NAND_P3 = 3'h4;
  localparam logic [2:0] SRC_NOR_P3_P0 = 3'h5;
  localparam logic [2:0] SRC_NAND_P3_P0 = 3'h6;
  localparam int ST_STOPPED_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_TERM_BIT = 2;
  localparam int ST_RESERR_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [2:0] source;
    logic level;
  } recovery_cfg_t;

  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port2;
    logic [3:0] port3;
  } pin_group_t;

endpackage

// ===== recovery_gate.sv
// Combines the selected input pins into the NAND or NOR recovery term.
`timescale 1ns/1ps
module recovery_gate
  import stop_recovery_pkg::*;
(
  // Configuration.
  input wire recovery_cfg_t cfg_in,
  // Synchronised pin levels and directions, one means output.
  input wire pin_group_t pins_in,
  input wire pin_group_t is_out_in,
  // Gate term after the level compare.
  output logic term_out
);

  logic [19:0] sel;
  logic [19:0] use_pin;
  logic nand_g;
  logic nor_g;
  logic gate;

  always_comb begin
    sel = '0;
    case (cfg_in.source)
      SRC_NAND_P2_LO: sel[7:4] = 4'hf;
      SRC_NAND_P2_ALL: sel[11:4] = 8'hff;
      SRC_NOR_P3, SRC_NAND_P3: sel[3:1] = 3'h7;
      SRC_NOR_P3_P0, SRC_NAND_P3_P0: begin
        sel[3:1] = 3'h7;
        sel[12] = 1'b1;
        sel[19] = 1'b1;
      end
      default: sel = '0;
    endcase
  end

  // Output pins drop out; an empty group gives no term.
  assign use_pin = sel & ~is_out_in;
  assign nand_g = |(use_pin & ~pins_in);
  assign nor_g = (use_pin != '0) && ((use_pin & pins_in) == '0);

  always_comb begin
    case (cfg_in.source)
      SRC_NOR_P3, SRC_NOR_P3_P0: gate = nor_g;
      SRC_NAND_P2_LO, SRC_NAND_P2_ALL, SRC_NAND_P3, SRC_NAND_P3_P0:
        gate = nand_g;
      default: gate = 1'b0;
    endcase
  end

  // Level select at the XOR input; no selected input pin gives no term.
  assign term_out = (use_pin != '0) && (gate ^ ~cfg_in.level);

endmodule

// ===== pin_board_model.sv
// Board model that drives the port pins and their direction lines.
`timescale 1ns/1ps
module pin_board_model
  import stop_recovery_pkg::*;
(
  // Clock.
  input wire logic clk_sys_in,
  // Levels the board applies and pins the core drives itself.
  input wire pin_group_t level_in,
  input wire pin_group_t dir_in,
  // Pin levels and directions seen by the block.
  output pin_group_t pins_out,
  output pin_group_t is_out_out
);
  pin_group_t wiggle_r = '0;

  // The board releases output pins, so they show a changing pattern.
  always_ff @(posedge clk_sys_in) begin
    wiggle_r <= ~wiggle_r;
  end

  assign pins_out = (level_in & ~dir_in) | (wiggle_r & dir_in);
  assign is_out_out = dir_in;
endmodule

// ===== test_stop_recovery_select.sv
// Self-checking bench for the stop mode recovery select block.
`timescale 1ns/1ps
module test_stop_recovery_select
  import stop_recovery_pkg::*;
;
  logic clk = 1'b0;
  logic rstn, awv, wv, bre, arv, rre, stopped, primary;
  logic awr, wrdy, bv, arr, rv, wake;
  logic [31:0] awa, wd, ara, rd, seed, got;
  logic [3:0] strb;
  logic [1:0] br, rr;
  pin_group_t lvl, dir, pins, isout;
  int errors, comparisons;

  always #4 clk = ~clk;

  stop_recovery_select stop_recovery_select_inst (
    .clk_sys_in(clk), .rstn_in(rstn),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
    .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rre), .pins_in(pins), .pin_is_out_in(isout),
    .stopped_in(stopped), .primary_wake_in(primary), .wake_out(wake));

  pin_board_model pin_board_model_inst (.clk_sys_in(clk),
    .level_in(lvl), .dir_in(dir), .pins_out(pins), .is_out_out(isout));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic exp_term(input logic [2:0] c, input logic lv,
      input pin_group_t p, input pin_group_t o);
    pin_group_t m;
    logic g;
    m = '0;
    if (c == 3'h1) m.port2 = 8'h0f;
    if (c == 3'h2) m.port2 = 8'hff;
    if (c >= 3'h3 && c <= 3'h6) m.port3 = 4'he;
    if (c >= 3'h5 && c <= 3'h6) m.port0 = 8'h81;
    m = m & ~o;
    g = (c == 3'h3 || c == 3'h5) ? ((m & p) == '0) : ((m & ~p) != '0);
    return (m != '0) && (g ^ !lv);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [31:0] a, d, input logic [1:0] er);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    bre <= 1'b0;
    check("bresp", 32'(br), 32'(er));
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [31:0] a, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rre <= 1'b0;
    got = rd;
    check("rresp", 32'(rr), 32'(er));
    @(posedge clk);
  endtask

  task automatic settle_check(input logic [2:0] c, input logic lv);
    logic t;
    repeat (5) @(posedge clk);
    t = exp_term(c, lv, lvl, dir);
    rd_reg(STATUS_ADDR, RESP_OKAY);
    check("term", 32'(got[ST_TERM_BIT]), 32'(t));
    check("wake", 32'(wake), 32'(stopped & (t | primary)));
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    wrap_up;
  end

  initial begin
    errors = 0;
    comparisons = 0;
    seed = 32'h0000_0011;
    {rstn, awv, wv, bre, arv, rre, stopped, primary} = '0;
    {awa, wd, ara} = '0;
    strb = 4'hf;
    lvl = '0;
    dir = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    settle_check(SRC_RESET, LEVEL_RESET);
    rd_reg(SEL2_ADDR, RESP_OKAY);
    check("select read", got, 32'h0);
    rd_reg(32'h0000_0080, RESP_DECERR);
    wr_reg(32'h0000_0080, 32'h0, RESP_DECERR);
    stopped <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      lvl <= i[4] ? pin_group_t'(seed[19:0]) : '0;
      seed = lfsr(seed);
      dir <= (i == 18) ? '1 :
             i[4] ? pin_group_t'(seed[19:0] & seed[27:8]) : '0;
      wr_reg(SEL2_ADDR, {25'h0, i[3], 1'b0, i[2:0], 2'h0}, RESP_OKAY);
      settle_check(i[2:0], i[3]);
    end
    wr_reg(SEL2_ADDR, 32'h0, RESP_OKAY);
    primary <= 1'b1;
    settle_check(SRC_POR_ONLY, 1'b0);
    stopped <= 1'b0;
    settle_check(SRC_POR_ONLY, 1'b0);
    primary <= 1'b0;
    wr_reg(SEL2_ADDR, 32'h0000_0080, RESP_OKAY);
    rd_reg(STATUS_ADDR, RESP_OKAY);
    check("reserved flag", 32'(got[ST_RESERR_BIT]), 32'h1);
    wr_reg(CTRL_ADDR, 32'h0000_0008, RESP_OKAY);
    rd_reg(STATUS_ADDR, RESP_OKAY);
    check("flag clear", 32'(got[ST_RESERR_BIT]), 32'h0);
    wrap_up;
  end
endmodule
